// ==== rtl/qaw_judge.sv ====
// Question-and-answer watchdog sequence judge with register port
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "qaw_regs.svh"

module qaw_judge #(
  parameter int ADDR_W = 8
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic [ADDR_W-1:0]     addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  input  wire logic                  in_close_window,
  input  wire logic                  time_out,
  input  wire logic                  window_lock,
  output logic      [31:0]           rdata,
  output logic      [3:0]            question,
  output logic      [`QAW_WIN_W-1:0] open_window_length,
  output logic      [`QAW_WIN_W-1:0] close_window_length,
  output logic      [2:0]            fail_counter,
  output logic                       sequence_start,
  output logic                       irq
);
  import qaw_pkg::*;

  // ------------------------------------------------------------------
  // Reference answers
  // ------------------------------------------------------------------
  function automatic logic [7:0] ref_answer(input logic [3:0] q, input logic [1:0] cnt);
    logic [7:0] a3;
    a3 = 8'h00;
    case (q)
      4'h0: a3 = 8'hFF;
      4'h1: a3 = 8'hB0;
      4'h2: a3 = 8'hE9;
      4'h3: a3 = 8'hA6;
      4'h4: a3 = 8'h75;
      4'h5: a3 = 8'h3A;
      4'h6: a3 = 8'h63;
      4'h7: a3 = 8'h2C;
      4'h8: a3 = 8'hD2;
      4'h9: a3 = 8'h9D;
      4'hA: a3 = 8'hC4;
      4'hB: a3 = 8'h8B;
      4'hC: a3 = 8'h58;
      4'hD: a3 = 8'h17;
      4'hE: a3 = 8'h4E;
      default: a3 = 8'h01;
    endcase
    case (cnt)
      2'h3: ref_answer = a3;
      2'h2: ref_answer = {~a3[7:4], a3[3:0]};
      2'h1: ref_answer = {a3[7:4], ~a3[3:0]};
      default: ref_answer = ~a3;
    endcase
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  qaw_state_t   cur;
  qaw_state_t   next_cur;
  qaw_outcome_t outcome;
  logic         wr_answer;
  logic         wr_cfg;
  logic         mismatch;
  logic         err_all;
  logic [`QAW_EV_W-1:0] ev;

  always_comb begin
    next_cur = cur;
    next_cur.sequence_start = 1'b0;
    outcome   = QAW_OUT_NONE;
    ev        = '0;
    wr_answer = wr && hit(addr, `QAW_OFF_ANSWER);
    wr_cfg    = wr && (hit(addr, `QAW_OFF_OPEN_WIN) || hit(addr, `QAW_OFF_CLOSE_WIN));
    mismatch  = wdata[7:0] != ref_answer(cur.question, cur.answer_byte_counter);
    err_all   = cur.answer_error || mismatch;

    // Answer bytes
    if (wr_answer) begin
      if (cur.answer_byte_counter != 2'h0) begin
        next_cur.answer_error = err_all;
        next_cur.answer_byte_counter = cur.answer_byte_counter - 2'h1;
      end else if (!err_all && in_close_window) begin
        outcome = QAW_OUT_GOOD;
      end else begin
        outcome = QAW_OUT_BAD;
      end
    end else if (time_out) begin
      outcome = QAW_OUT_TIMEOUT;
    end

    // Window length writes
    if (wr_cfg) begin
      outcome = QAW_OUT_CFG;
      if (!window_lock && hit(addr, `QAW_OFF_OPEN_WIN)) begin
        next_cur.open_window_length = wdata[`QAW_WIN_W-1:0];
      end
      if (!window_lock && hit(addr, `QAW_OFF_CLOSE_WIN)) begin
        next_cur.close_window_length = wdata[`QAW_WIN_W-1:0];
      end
    end

    // Sequence outcome
    case (outcome)
      QAW_OUT_GOOD: begin
        if (cur.fail_counter != 3'h0) begin
          next_cur.fail_counter = cur.fail_counter - 3'h1;
        end
        next_cur.question = cur.question + 4'h1;
        next_cur.sequence_error_flag = 1'b0;
        next_cur.answer_early_flag = 1'b0;
        next_cur.time_out_flag = 1'b0;
        next_cur.window_setting_changed_flag = 1'b0;
        ev[`QAW_EV_GOOD] = 1'b1;
      end
      QAW_OUT_BAD: begin
        next_cur.sequence_error_flag = 1'b1;
        next_cur.answer_early_flag = !in_close_window;
        next_cur.time_out_flag = 1'b0;
        next_cur.window_setting_changed_flag = 1'b0;
        ev[`QAW_EV_BAD] = 1'b1;
      end
      QAW_OUT_TIMEOUT: begin
        next_cur.time_out_flag = 1'b1;
        next_cur.sequence_error_flag = cur.answer_error;
        next_cur.answer_early_flag = 1'b0;
        next_cur.window_setting_changed_flag = 1'b0;
        ev[`QAW_EV_TIMEOUT] = 1'b1;
      end
      QAW_OUT_CFG: begin
        next_cur.window_setting_changed_flag = 1'b1;
        next_cur.sequence_error_flag = 1'b0;
        next_cur.answer_early_flag = 1'b0;
        next_cur.time_out_flag = 1'b0;
        ev[`QAW_EV_CFG] = 1'b1;
      end
      default: begin
      end
    endcase

    if (outcome != QAW_OUT_NONE) begin
      if (outcome != QAW_OUT_GOOD && cur.fail_counter != `QAW_FAIL_MAX) begin
        next_cur.fail_counter = cur.fail_counter + 3'h1;
      end
      next_cur.answer_byte_counter = `QAW_ANS_CNT_START;
      next_cur.answer_error = 1'b0;
      next_cur.sequence_start = 1'b1;
    end

    // Interrupt registers, set wins over clear
    if (wr && hit(addr, `QAW_OFF_IRQ_MASK)) begin
      next_cur.irq_mask = wdata[`QAW_EV_W-1:0];
    end
    if (wr && hit(addr, `QAW_OFF_IRQ_STATUS)) begin
      next_cur.irq_status = cur.irq_status & ~wdata[`QAW_EV_W-1:0];
    end
    next_cur.irq_status = next_cur.irq_status | ev;
    next_cur.irq = |(next_cur.irq_status & next_cur.irq_mask);

    // Read data, valid the cycle after the strobe
    next_cur.rdata = 32'h0000_0000;
    if (rd) begin
      if (hit(addr, `QAW_OFF_STATUS)) begin
        next_cur.rdata[`QAW_ST_TIME_OUT] = cur.time_out_flag;
        next_cur.rdata[`QAW_ST_CFG_CHG] = cur.window_setting_changed_flag;
        next_cur.rdata[`QAW_ST_EARLY] = cur.answer_early_flag;
        next_cur.rdata[`QAW_ST_SEQUENCE_ERROR_FLAG] = cur.sequence_error_flag;
        next_cur.rdata[`QAW_ST_ANS_ERR] = cur.answer_error;
        next_cur.rdata[`QAW_ST_ANS_CNT_LO +: 2] = cur.answer_byte_counter;
        next_cur.rdata[`QAW_ST_FAIL_LO +: 3] = cur.fail_counter;
      end else if (hit(addr, `QAW_OFF_OPEN_WIN)) begin
        next_cur.rdata[`QAW_WIN_W-1:0] = cur.open_window_length;
      end else if (hit(addr, `QAW_OFF_CLOSE_WIN)) begin
        next_cur.rdata[`QAW_WIN_W-1:0] = cur.close_window_length;
      end else if (hit(addr, `QAW_OFF_QUESTION)) begin
        next_cur.rdata[3:0] = cur.question;
      end else if (hit(addr, `QAW_OFF_IRQ_STATUS)) begin
        next_cur.rdata[`QAW_EV_W-1:0] = cur.irq_status;
      end else if (hit(addr, `QAW_OFF_IRQ_MASK)) begin
        next_cur.rdata[`QAW_EV_W-1:0] = cur.irq_mask;
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cur <= '0;
      cur.question <= `QAW_QUESTION_RST;
      cur.answer_byte_counter <= `QAW_ANS_CNT_START;
      cur.fail_counter <= `QAW_FAIL_RST;
      cur.open_window_length <= `QAW_WIN_RST;
      cur.close_window_length <= `QAW_WIN_RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata               = cur.rdata;
  assign question            = cur.question;
  assign open_window_length  = cur.open_window_length;
  assign close_window_length = cur.close_window_length;
  assign fail_counter        = cur.fail_counter;
  assign sequence_start      = cur.sequence_start;
  assign irq                 = cur.irq;

endmodule
`default_nettype wire

// ==== rtl/qaw_regs.svh ====
// Offsets, field positions, reset values and widths of the answer judge
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`ifndef QAW_REGS_SVH
`define QAW_REGS_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define QAW_OFF_ANSWER      8'h00
`define QAW_OFF_OPEN_WIN    8'h04
`define QAW_OFF_CLOSE_WIN   8'h08
`define QAW_OFF_STATUS      8'h0C
`define QAW_OFF_QUESTION    8'h10
`define QAW_OFF_IRQ_STATUS  8'h14
`define QAW_OFF_IRQ_MASK    8'h18

// ------------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------------
`define QAW_ST_TIME_OUT     0
`define QAW_ST_CFG_CHG      1
`define QAW_ST_EARLY        2
`define QAW_ST_SEQUENCE_ERROR_FLAG      3
`define QAW_ST_ANS_ERR      4
`define QAW_ST_ANS_CNT_LO   5
`define QAW_ST_FAIL_LO      8

// ------------------------------------------------------------------
// Interrupt event bits
// ------------------------------------------------------------------
`define QAW_EV_GOOD         0
`define QAW_EV_BAD          1
`define QAW_EV_TIMEOUT      2
`define QAW_EV_CFG          3
`define QAW_EV_W            4

// ------------------------------------------------------------------
// Widths and reset values
// ------------------------------------------------------------------
`define QAW_WIN_W           8
`define QAW_ANS_CNT_START   2'h3
`define QAW_FAIL_RST        3'h0
`define QAW_FAIL_MAX        3'h7
`define QAW_WIN_RST         8'h00
`define QAW_QUESTION_RST    4'h0

`endif

// ==== rtl/qaw_pkg.sv ====
// Types of the answer judge
`include "qaw_regs.svh"

package qaw_pkg;

  typedef enum logic [2:0] {
    QAW_OUT_NONE,
    QAW_OUT_GOOD,
    QAW_OUT_BAD,
    QAW_OUT_TIMEOUT,
    QAW_OUT_CFG
  } qaw_outcome_t;

  typedef struct packed {
    logic [3:0]             question;
    logic [1:0]             answer_byte_counter;
    logic                   answer_error;
    logic [2:0]             fail_counter;
    logic                   sequence_error_flag;
    logic                   time_out_flag;
    logic                   window_setting_changed_flag;
    logic                   answer_early_flag;
    logic [`QAW_WIN_W-1:0]  open_window_length;
    logic [`QAW_WIN_W-1:0]  close_window_length;
    logic [`QAW_EV_W-1:0]   irq_status;
    logic [`QAW_EV_W-1:0]   irq_mask;
    logic                   irq;
    logic                   sequence_start;
    logic [31:0]            rdata;
  } qaw_state_t;

endpackage

// ==== testbench/qaw_judge_sva.sv ====
// Port assertions of the answer judge
`timescale 1ns/1ps
`default_nettype none
`include "qaw_regs.svh"
module qaw_judge_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire logic [ADDR_W-1:0]     addr,
  input wire logic                  wr,
  input wire logic                  time_out,
  input wire logic                  window_lock,
  input wire logic [31:0]           rdata,
  input wire logic [3:0]            question,
  input wire logic [`QAW_WIN_W-1:0] open_window_length,
  input wire logic [2:0]            fail_counter,
  input wire logic                  sequence_start,
  input wire logic                  irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  function automatic logic [2:0] up(input logic [2:0] f);
    return (f == 3'h7) ? f : f + 3'h1;
  endfunction
  function automatic logic [2:0] dn(input logic [2:0] f);
    return (f == 3'h0) ? f : f - 3'h1;
  endfunction
  sequence win_wr_s;
    wr && (addr == `QAW_OFF_OPEN_WIN || addr == `QAW_OFF_CLOSE_WIN);
  endsequence
  sequence kept_s;
    sequence_start && $stable(question) && fail_counter == up($past(fail_counter));
  endsequence
  reset_values_a: assert property (disable iff (1'b0)
    rst |=> rdata == 32'h0000_0000 && question == 4'h0 && fail_counter == 3'h0 && !sequence_start && !irq)
    else $error("reset values wrong");
  cfg_event_a: assert property (win_wr_s |=> kept_s)
    else $error("window write outcome wrong");
  lock_hold_a: assert property (wr && addr == `QAW_OFF_OPEN_WIN && window_lock |=> $stable(open_window_length))
    else $error("locked window length changed");
  q_step_a: assert property (!$past(rst) && $changed(question) |->
    question == $past(question) + 4'h1 && sequence_start) else $error("question step wrong");
  good_fail_a: assert property (!$past(rst) && $changed(question) |->
    fail_counter == dn($past(fail_counter))) else $error("good event fail count wrong");
  time_out_a: assert property (time_out && !wr |=> kept_s)
    else $error("time-out outcome wrong");
  start_cause_a: assert property (!$past(rst) && sequence_start |-> $past(wr) || $past(time_out))
    else $error("sequence start without cause");
  fail_move_a: assert property (!$past(rst) && $changed(fail_counter) |-> sequence_start)
    else $error("fail counter moved outside outcome");
  cfg_c: cover property (win_wr_s ##1 sequence_start);
endmodule
bind qaw_judge qaw_judge_sva #(.ADDR_W(ADDR_W)) u_qaw_judge_sva (.sys_clk(sys_clk), .rst(rst), .addr(addr),
  .wr(wr), .time_out(time_out), .window_lock(window_lock), .rdata(rdata), .question(question),
  .open_window_length(open_window_length), .fail_counter(fail_counter), .sequence_start(sequence_start), .irq(irq));
`default_nettype wire

// ==== testbench/qaw_mcu.sv ====
// Microcontroller model writing answer bytes
`timescale 1ns/1ps
`default_nettype none
module qaw_mcu (
  input  wire logic       sys_clk,
  input  wire logic [3:0] question,
  output logic            wr,
  output logic [7:0]      addr,
  output logic [31:0]     wdata
);
  logic [7:0] a3 [16] = '{8'hFF, 8'hB0, 8'hE9, 8'hA6, 8'h75, 8'h3A, 8'h63, 8'h2C,
                          8'hD2, 8'h9D, 8'hC4, 8'h8B, 8'h58, 8'h17, 8'h4E, 8'h01};
  initial begin
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
  end
  // Back-to-back answer writes, byte number bad flipped by x
  task automatic send(input int n, input int bad, input logic [7:0] x);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = a3[question];
      case (i)
        1: b = b ^ 8'hF0;
        2: b = b ^ 8'h0F;
        3: b = ~b;
        default: ;
      endcase
      if (i == bad) b = b ^ x;
      @(posedge sys_clk);
      wr <= 1'b1;
      wdata <= {24'h00_0000, b};
    end
    @(posedge sys_clk);
    wr <= 1'b0;
    wdata <= ~wdata;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench of the answer judge
`timescale 1ns/1ps
`default_nettype none
`include "qaw_regs.svh"
module tb;
  localparam logic [31:0] stm = 32'hFFFF_FFEF;
  logic        sys_clk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, rd_d = 1'b0;
  logic        in_close_window = 1'b0, time_out = 1'b0, window_lock = 1'b0, mcu_wr, sequence_start, irq;
  logic [7:0]  bus_addr = 8'h00, mcu_addr, open_window_length, close_window_length;
  logic [31:0] bus_wdata = 32'h0000_0000, mcu_wdata, rdata;
  logic [63:0] note, exp_q[$];
  logic [3:0]  question;
  logic [2:0]  fail_counter;
  int          mismatches = 0, check_count = 0;
  always #10 sys_clk = ~sys_clk;
  qaw_judge u_qaw_judge (.sys_clk(sys_clk), .rst(rst), .addr(mcu_wr ? mcu_addr : bus_addr),
    .wdata(mcu_wr ? mcu_wdata : bus_wdata), .wr(mcu_wr | bus_wr), .rd(bus_rd), .in_close_window(in_close_window),
    .time_out(time_out), .window_lock(window_lock), .rdata(rdata), .question(question),
    .open_window_length(open_window_length), .close_window_length(close_window_length),
    .fail_counter(fail_counter), .sequence_start(sequence_start), .irq(irq));
  qaw_mcu u_qaw_mcu (.sys_clk(sys_clk), .question(question), .wr(mcu_wr), .addr(mcu_addr), .wdata(mcu_wdata));
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    bus_wdata <= ~d;
  endtask
  task automatic br(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    @(posedge sys_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    exp_q.push_back({m, e & m});
    @(posedge sys_clk);
    bus_rd <= 1'b0;
  endtask
  task automatic pulse_to();
    @(posedge sys_clk);
    time_out <= 1'b1;
    @(posedge sys_clk);
    time_out <= 1'b0;
  endtask
  task automatic ck_irq(input logic e);
    repeat (2) @(posedge sys_clk);
    #1;
    check_count++;
    if (irq !== e) begin
      mismatches++;
      $display("[ERR] %0t irq %b", $time, irq);
    end
  endtask
  function automatic logic [31:0] st(input logic [2:0] fc, input logic [1:0] c, input logic [3:0] fl);
    return {21'h00_0000, fc, 1'b0, c, 1'b0, fl};
  endfunction
  always @(posedge sys_clk) begin
    if (rd_d) begin
      note = exp_q.pop_front();
      check_count++;
      if ((rdata & note[63:32]) !== note[31:0]) begin
        mismatches++;
        $display("[ERR] %0t read %h expected %h", $time, rdata, note[31:0]);
      end
    end
    rd_d <= bus_rd;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    wrap_up();
  end
  initial begin
    void'($urandom(20241));
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    br(`QAW_OFF_STATUS, st(3'h0, 2'h3, 4'h0));
    bw(`QAW_OFF_OPEN_WIN, 32'h0000_0055);
    br(`QAW_OFF_STATUS, st(3'h1, 2'h3, 4'h2), stm);
    br(`QAW_OFF_OPEN_WIN, 32'h0000_0055);
    window_lock <= 1'b1;
    bw(`QAW_OFF_CLOSE_WIN, 32'h0000_0066);
    window_lock <= 1'b0;
    br(`QAW_OFF_CLOSE_WIN, 32'h0000_0000);
    br(`QAW_OFF_STATUS, st(3'h2, 2'h3, 4'h2), stm);
    $display("window tests done");
    u_qaw_mcu.send(4, 9, 8'h00);
    br(`QAW_OFF_STATUS, st(3'h3, 2'h3, 4'hC), stm);
    in_close_window <= 1'b1;
    u_qaw_mcu.send(4, $urandom_range(3), 8'(1 + $urandom_range(254)));
    br(`QAW_OFF_STATUS, st(3'h4, 2'h3, 4'h8), stm);
    in_close_window <= 1'b0;
    u_qaw_mcu.send(4, $urandom_range(3), 8'(1 + $urandom_range(254)));
    br(`QAW_OFF_STATUS, st(3'h5, 2'h3, 4'hC), stm);
    u_qaw_mcu.send(1, 0, 8'h5A);
    pulse_to();
    br(`QAW_OFF_STATUS, st(3'h6, 2'h3, 4'h9), stm);
    u_qaw_mcu.send(2, 9, 8'h00);
    br(`QAW_OFF_STATUS, st(3'h6, 2'h1, 4'h9), stm);
    pulse_to();
    br(`QAW_OFF_STATUS, st(3'h7, 2'h3, 4'h1), stm);
    br(`QAW_OFF_QUESTION, 32'h0000_0000);
    $display("bad event tests done");
    ck_irq(1'b0);
    bw(`QAW_OFF_IRQ_MASK, 32'h0000_0004);
    ck_irq(1'b1);
    bw(`QAW_OFF_IRQ_STATUS, 32'h0000_0004);
    ck_irq(1'b0);
    br(`QAW_OFF_IRQ_STATUS, 32'h0000_000A);
    br(8'h1C, 32'h0000_0000);
    $display("interrupt tests done");
    in_close_window <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      u_qaw_mcu.send(4, 9, 8'h00);
      br(`QAW_OFF_STATUS, st(3'(i < 7 ? 6 - i : 0), 2'h3, 4'h0), stm);
      br(`QAW_OFF_QUESTION, 32'((i + 1) % 16));
    end
    bw(`QAW_OFF_CLOSE_WIN, 32'h0000_0066);
    br(`QAW_OFF_CLOSE_WIN, 32'h0000_0066);
    br(`QAW_OFF_STATUS, st(3'h1, 2'h3, 4'h2), stm);
    check_count++;
    if (open_window_length !== 8'h55 || close_window_length !== 8'h66) begin
      mismatches++;
      $display("[ERR] %0t window ports %h %h", $time, open_window_length, close_window_length);
    end
    $display("good event tests done");
    repeat (3) @(posedge sys_clk);
    wrap_up();
  end
endmodule
`default_nettype wire
